/* rre_defines.vh */
// constants for the rom read-out encryption block
// assumes a byte-wide rom and a 16-bit code address space
`ifndef RRE_DEFINES_VH
`define RRE_DEFINES_VH
`define RRE_ADDR_W        16
`define RRE_DATA_W        8
`define RRE_VARIANT_4K    2'h0
`define RRE_VARIANT_8K    2'h1
`define RRE_VARIANT_16K   2'h2
`define RRE_VARIANT_32K   2'h3
`define RRE_KEY_LINES_4K  7
`define RRE_KEY_LINES_8K  8
`define RRE_KEY_LINES_16K 9
`define RRE_KEY_LINES_32K 10
`define RRE_KEY_DEPTH_MAX 1024
`define RRE_KEY_AW_MAX    10
`define RRE_LIMIT_4K      16'h1000
`define RRE_LIMIT_8K      16'h2000
`define RRE_LIMIT_16K     16'h4000
`define RRE_LIMIT_32K     16'h8000
`define RRE_ZERO_BYTE     8'h00
`define RRE_ZERO_ADDR     16'h0000
`define RRE_KEY_SEED      8'hA5
`endif

/* rre_key_rom.v */
// encryption key array, fixed contents, registered read data
// assumes the parent only ever presents its output through the xnor path
`timescale 1ns/100ps
`default_nettype none
`include "rre_defines.vh"
module rre_key_rom #(
    parameter DEPTH = `RRE_KEY_DEPTH_MAX,   // key bytes
    parameter AW    = `RRE_KEY_AW_MAX,      // index width
    parameter [7:0] SEED = `RRE_KEY_SEED    // arbitrary per-application seed
)(
    input  wire          ref_clk,   // core clock
    input  wire          sys_rst,   // async reset, active high
    input  wire [AW-1:0] rd_idx,    // key index
    output reg  [7:0]    rd_data_ff // key byte, registered
);
    // key contents as a constant function; mask-fixed, no write port
    function [7:0] key_byte;
        input [AW-1:0] i;
        reg   [15:0]   w;
        begin
            w        = {{(16-AW){1'b0}}, i};
            key_byte = SEED ^ w[7:0] ^ {w[4:0], w[9:8], 1'b1} ^ {1'b0, w[15:9]};
        end
    endfunction

    // registered read keeps the key off any combinational external path
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            rd_data_ff <= `RRE_ZERO_BYTE;
        else
            rd_data_ff <= key_byte(rd_idx);
    end
endmodule // rre_key_rom
`default_nettype wire

/* rre_readout.v */
// rom read-out encryption: access-select latch, fetch steering, data scrambling
// assumes rom data are valid in the same cycle rom_addr is driven; core holds request one cycle
`timescale 1ns/100ps
`default_nettype none
`include "rre_defines.vh"
module rre_readout #(
    parameter [1:0] VARIANT = `RRE_VARIANT_4K,  // rom size variant
    parameter [7:0] KEY_SEED = `RRE_KEY_SEED    // arbitrary key seed
)(
    input  wire        ref_clk,                 // core clock, 10 MHz
    input  wire        sys_rst,                 // async reset, active high
    input  wire        external_access_select,  // access select pin
    input  wire        req_valid,               // core or tester access strobe
    input  wire        req_fetch,               // 1 instruction fetch
    input  wire        req_table,               // 1 code_table_read
    input  wire        req_verify,              // 1 program verification read
    input  wire [15:0] req_pc,                  // program counter of requester
    input  wire [15:0] req_addr,                // fetch or data pointer address
    input  wire [7:0]  rom_rdata,               // internal rom data
    input  wire [7:0]  ext_rdata,               // external memory data
    output reg  [15:0] rom_addr_ff,             // internal rom address
    output reg         rom_rd_ff,               // internal rom read strobe
    output reg  [15:0] ext_addr_ff,             // external memory address
    output reg         ext_rd_ff,               // external memory read strobe
    output reg  [7:0]  core_rdata_ff,           // data to core, raw
    output reg         core_rvalid_ff,          // core data valid pulse
    output reg  [7:0]  port0_out_ff,            // port 0 data out
    output reg         port0_oe_ff,             // port 0 drive enable
    output reg         ea_latched_ff            // latched access select
);
    // key geometry per variant
    localparam KEY_LINES = (VARIANT == `RRE_VARIANT_4K)  ? `RRE_KEY_LINES_4K :
                           (VARIANT == `RRE_VARIANT_8K)  ? `RRE_KEY_LINES_8K :
                           (VARIANT == `RRE_VARIANT_16K) ? `RRE_KEY_LINES_16K :
                                                           `RRE_KEY_LINES_32K;
    localparam KEY_DEPTH = 1 << KEY_LINES;
    localparam [15:0] LIMIT = (VARIANT == `RRE_VARIANT_4K)  ? `RRE_LIMIT_4K :
                              (VARIANT == `RRE_VARIANT_8K)  ? `RRE_LIMIT_8K :
                              (VARIANT == `RRE_VARIANT_16K) ? `RRE_LIMIT_16K :
                                                              `RRE_LIMIT_32K;

    // is an address inside internal rom, given the latched select
    function is_internal;
        input        ea;
        input [15:0] a;
        begin
            is_internal = ea & (a < LIMIT);
        end
    endfunction

    // reset-caught select; first clean edge after release takes the pin
    reg        ea_taken_ff;   // 1 once the select has been captured
    reg        pend_int_ff;   // pending internal access
    reg        pend_ext_ff;   // pending external access
    reg        pend_enc_ff;   // pending result to be scrambled
    reg        pend_core_ff;  // pending result goes to core
    reg        pend_port_ff;  // pending result goes to port 0
    wire [7:0] key_byte;      // key byte, aligned with rom data

    // latch the select once after reset; later pin changes ignored
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ea_taken_ff   <= 1'b0;
            ea_latched_ff <= 1'b0;
        end
        else if (!ea_taken_ff)
        begin
            ea_taken_ff   <= 1'b1;
            ea_latched_ff <= external_access_select;
        end
    end

    // key index from low rom address lines; key never leaves except xnor'ed
    rre_key_rom #(
        .DEPTH (KEY_DEPTH),
        .AW    (KEY_LINES),
        .SEED  (KEY_SEED)
    ) u_key (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .rd_idx     (req_addr[KEY_LINES-1:0]),
        .rd_data_ff (key_byte)
    );

    // decode request: where to read, whether to scramble
    reg d_int;   // access goes internal
    reg d_enc;   // scramble returned byte
    always @*
    begin
        d_int = is_internal(ea_latched_ff, req_addr);
        d_enc = 1'b0;
        if (req_verify)
        begin
            d_int = 1'b1;                                     // verify always reads rom
            d_enc = 1'b1;
        end
        else if (req_table)
            // only external code reaching internal rom is scrambled
            d_enc = d_int & ~is_internal(ea_latched_ff, req_pc);
        else if (req_fetch)
            d_enc = 1'b0;
    end

    // issue stage: drive memory address and strobes
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rom_addr_ff  <= `RRE_ZERO_ADDR;
            rom_rd_ff    <= 1'b0;
            ext_addr_ff  <= `RRE_ZERO_ADDR;
            ext_rd_ff    <= 1'b0;
            pend_int_ff  <= 1'b0;
            pend_ext_ff  <= 1'b0;
            pend_enc_ff  <= 1'b0;
            pend_core_ff <= 1'b0;
            pend_port_ff <= 1'b0;
        end
        else
        begin
            // requests before the select is caught are dropped
            rom_rd_ff    <= req_valid & ea_taken_ff & d_int;
            ext_rd_ff    <= req_valid & ea_taken_ff & ~d_int;
            pend_int_ff  <= req_valid & ea_taken_ff & d_int;
            pend_ext_ff  <= req_valid & ea_taken_ff & ~d_int;
            pend_enc_ff  <= d_enc;
            // scrambled table bytes go to port 0 only, never to the core
            pend_core_ff <= ~req_verify & ~(req_table & d_enc);
            pend_port_ff <= req_verify | (req_table & d_enc);
            if (req_valid & d_int)
                rom_addr_ff <= req_addr;
            if (req_valid & ~d_int)
                ext_addr_ff <= req_addr;
        end
    end

    // return stage: select source and apply xnor scrambling
    reg [7:0] ret_byte;   // returned byte before registering
    always @*
    begin
        ret_byte = pend_int_ff ? rom_rdata : ext_rdata;
        if (pend_int_ff & pend_enc_ff)
            ret_byte = ~(rom_rdata ^ key_byte);
    end

    // outputs; scrambled bytes never reach the raw core path
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            core_rdata_ff  <= `RRE_ZERO_BYTE;
            core_rvalid_ff <= 1'b0;
            port0_out_ff   <= `RRE_ZERO_BYTE;
            port0_oe_ff    <= 1'b0;
        end
        else
        begin
            core_rvalid_ff <= (pend_int_ff | pend_ext_ff) & pend_core_ff;
            port0_oe_ff    <= (pend_int_ff | pend_ext_ff) & pend_port_ff;
            if ((pend_int_ff | pend_ext_ff) & pend_core_ff)
                core_rdata_ff <= ret_byte;
            if ((pend_int_ff | pend_ext_ff) & pend_port_ff)
                port0_out_ff <= ret_byte;
        end
    end
endmodule // rre_readout
`default_nettype wire

/* rre_readout_properties.sv */
// port-level assertions for the rom read-out block
// assumes a bind onto rre_readout and one clock domain
`timescale 1ns/100ps
`default_nettype none
module rre_readout_chk #(
    parameter [1:0] VARIANT = 2'h0  // rom size variant
)(
    input wire logic        ref_clk,        // core clock
    input wire logic        sys_rst,        // async reset
    input wire logic        req_valid,      // request strobe
    input wire logic        req_fetch,      // fetch kind
    input wire logic        req_table,      // table kind
    input wire logic        req_verify,     // verify kind
    input wire logic [15:0] req_pc,         // requester pc
    input wire logic [15:0] req_addr,       // request address
    input wire logic [7:0]  rom_rdata,      // rom data
    input wire logic [7:0]  ext_rdata,      // external data
    input wire logic [15:0] rom_addr_ff,    // rom address
    input wire logic        rom_rd_ff,      // rom strobe
    input wire logic        ext_rd_ff,      // external strobe
    input wire logic [7:0]  core_rdata_ff,  // core data
    input wire logic        core_rvalid_ff, // core valid
    input wire logic        port0_oe_ff,    // port 0 drive
    input wire logic        ea_latched_ff   // latched select
);
    localparam [15:0] LIMIT = 16'h1000 << VARIANT; // first external address
    logic up_ff; // select has been latched since reset
    // requests on the first edge after reset are dropped, so track it
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            up_ff <= 1'b0;
        else
            up_ff <= 1'b1;
    end
    wire logic tk  = req_valid && up_ff;                     // request taken
    wire logic v   = tk && req_verify;                       // verify wins
    wire logic t   = tk && !req_verify && req_table;         // table read
    wire logic f   = tk && !req_verify && !req_table && req_fetch; // fetch
    wire logic ext = !ea_latched_ff || req_addr >= LIMIT;    // external target
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_rom_port;
        rom_rd_ff && !ext_rd_ff ##1 port0_oe_ff && !core_rvalid_ff;
    endsequence
    sequence s_rom_core;
        rom_rd_ff ##1 core_rvalid_ff && !port0_oe_ff && core_rdata_ff == $past(rom_rdata);
    endsequence
    sequence s_ext_core;
        ext_rd_ff && !rom_rd_ff ##1 core_rvalid_ff && !port0_oe_ff
            && core_rdata_ff == $past(ext_rdata);
    endsequence
    property p_verify; v |=> s_rom_port; endproperty
    property p_tbl_enc; t && !ext && req_pc >= LIMIT |=> s_rom_port; endproperty
    property p_tbl_int; t && !ext && req_pc < LIMIT |=> s_rom_core; endproperty
    property p_tbl_ext; t && ext |=> s_ext_core; endproperty
    property p_fetch_int; f && !ext |=> s_rom_core; endproperty
    property p_fetch_ext; f && ext |=> s_ext_core; endproperty
    property p_rom_addr; v || (tk && !ext) |=> rom_addr_ff == $past(req_addr); endproperty
    property p_ea_hold; up_ff && $past(up_ff) |-> $stable(ea_latched_ff); endproperty
    a_verify: assert property (p_verify) else $error("verify not encrypted on port 0");
    a_tbl_enc: assert property (p_tbl_enc) else $error("external table read not encrypted");
    a_tbl_int: assert property (p_tbl_int) else $error("internal table read not plain");
    a_tbl_ext: assert property (p_tbl_ext) else $error("external memory read wrong");
    a_fetch_int: assert property (p_fetch_int) else $error("internal fetch not raw");
    a_fetch_ext: assert property (p_fetch_ext) else $error("fetch not sent external");
    a_rom_addr: assert property (p_rom_addr) else $error("rom address wrong");
    a_ea_hold: assert property (p_ea_hold) else $error("latched select changed");
endmodule // rre_readout_chk
bind rre_readout rre_readout_chk #(.VARIANT(VARIANT)) i_chk (.ref_clk, .sys_rst, .req_valid,
    .req_fetch, .req_table, .req_verify, .req_pc, .req_addr, .rom_rdata, .ext_rdata,
    .rom_addr_ff, .rom_rd_ff, .ext_rd_ff, .core_rdata_ff, .core_rvalid_ff, .port0_oe_ff,
    .ea_latched_ff);
`default_nettype wire

/* rre_mem_model.sv */
// internal rom and external memory seen from the block
// assumes data are sampled while the read strobe is high
`timescale 1ns/100ps
`default_nettype none
module rre_mem_model (
    input  wire logic [15:0] rom_addr,  // rom address
    input  wire logic        rom_rd,    // rom strobe
    input  wire logic [15:0] ext_addr,  // external address
    input  wire logic        ext_rd,    // external strobe
    output logic      [7:0]  rom_rdata, // rom data
    output logic      [7:0]  ext_rdata  // external data
);
    // idle rom bus and strobed external bus show the inverse so a stale sample never passes
    assign rom_rdata = {8{~rom_rd}} ^ rom_addr[7:0] ^ rom_addr[15:8] ^ 8'h3C;
    assign ext_rdata = {8{ext_rd}} ^ ext_addr[7:0] ^ ext_addr[15:8];
endmodule // rre_mem_model
`default_nettype wire

/* rre_readout_test.sv */
// self-checking bench for the rom read-out block, 4K variant
// assumes the memory model answers while strobes are high
`timescale 1ns/100ps
`default_nettype none
module rre_readout_test;
    logic ref_clk, sys_rst, external_access_select, req_valid, req_fetch, req_table, req_verify;
    logic [15:0] req_pc, req_addr, rom_addr_ff, ext_addr_ff;
    logic [7:0] rom_rdata, ext_rdata, core_rdata_ff, port0_out_ff;
    logic rom_rd_ff, ext_rd_ff, core_rvalid_ff, port0_oe_ff, ea_latched_ff;
    int n_fail, comparisons;
    rre_readout #(.VARIANT(2'h0)) i_dut (.ref_clk, .sys_rst, .external_access_select,
        .req_valid, .req_fetch, .req_table, .req_verify, .req_pc, .req_addr, .rom_rdata,
        .ext_rdata, .rom_addr_ff, .rom_rd_ff, .ext_addr_ff, .ext_rd_ff, .core_rdata_ff,
        .core_rvalid_ff, .port0_out_ff, .port0_oe_ff, .ea_latched_ff);
    rre_mem_model i_mem (.rom_addr(rom_addr_ff), .rom_rd(rom_rd_ff), .ext_addr(ext_addr_ff),
        .ext_rd(ext_rd_ff), .rom_rdata, .ext_rdata);
    function automatic [7:0] rv(input [15:0] a); return a[7:0] ^ a[15:8] ^ 8'h3C; endfunction
    function automatic [7:0] xv(input [15:0] a); return ~a[7:0] ^ a[15:8]; endfunction
    // encrypted byte: 7 low lines pick the key, seed 0xA5 is arbitrary
    function automatic [7:0] ev(input [15:0] a);
        return ~(rv(a) ^ 8'hA5 ^ {1'b0, a[6:0]} ^ {a[4:0], 3'h1});
    endfunction
    task finish_test;
        if (n_fail == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task rst(input logic ea);
        sys_rst <= 1'b1;
        external_access_select <= ea;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    // one request, answer checked two edges later on port 0 or core side
    task xfer(input [2:0] k, input [15:0] pc, input [15:0] a, input logic prt, input [7:0] e);
        @(posedge ref_clk);
        req_valid <= 1'b1;
        {req_verify, req_table, req_fetch} <= k;
        req_pc <= pc;
        req_addr <= a;
        @(posedge ref_clk);
        req_valid <= 1'b0;
        @(posedge ref_clk);
        #1;
        comparisons++;
        if ((prt ? (port0_oe_ff !== 1'b1 || port0_out_ff !== e)
                 : (core_rvalid_ff !== 1'b1 || core_rdata_ff !== e))
            || port0_oe_ff !== prt || core_rvalid_ff !== !prt)
        begin
            n_fail++;
            $display("Error %0t: bad read at %h", $time, a);
        end
    endtask
    task t_verify;
        rst(1'b1);
        xfer(3'b100, 16'h0000, 16'h0010, 1'b1, ev(16'h0010));
        xfer(3'b110, 16'h2000, 16'h0FFF, 1'b1, ev(16'h0FFF));
        xfer(3'b100, 16'h0000, 16'h0090, 1'b1, ev(16'h0090));
    endtask
    task t_tables;
        rst(1'b1);
        xfer(3'b010, 16'h0FFF, 16'h0FFF, 1'b0, rv(16'h0FFF));
        xfer(3'b010, 16'h0100, 16'h1000, 1'b0, xv(16'h1000));
        xfer(3'b010, 16'h1000, 16'h0FFF, 1'b1, ev(16'h0FFF));
        xfer(3'b010, 16'h8000, 16'h1000, 1'b0, xv(16'h1000));
        xfer(3'b001, 16'h0FFF, 16'h0FFF, 1'b0, rv(16'h0FFF));
        xfer(3'b001, 16'h1000, 16'h1000, 1'b0, xv(16'h1000));
    endtask
    task t_ea_low;
        rst(1'b0);
        external_access_select <= 1'b1;
        xfer(3'b010, 16'h2000, 16'h0010, 1'b0, xv(16'h0010));
        xfer(3'b001, 16'h0010, 16'h0010, 1'b0, xv(16'h0010));
        comparisons++;
        if (ea_latched_ff !== 1'b0)
        begin
            n_fail++;
            $display("Error %0t: select latched after reset", $time);
        end
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial
    begin
        #(100 * 3000);
        n_fail++;
        finish_test;
    end
    initial
    begin
        {sys_rst, external_access_select, req_valid, req_fetch, req_table, req_verify} = 6'h21;
        {req_pc, req_addr} = 32'h0;
        n_fail = 0;
        comparisons = 0;
        t_verify;
        t_tables;
        t_ea_low;
        finish_test;
    end
endmodule // rre_readout_test
`default_nettype wire
